// file: verilog/bsz_bus_unit.v
// Behaviour
// - Narrow width select splits 32-bit requests.
// - Width taken from inputs before done.
// - Mask forces address bit 20 low.
// - Mask input synchronised as asynchronous.
// - Stop states park strobes, hold others but enables, grant and reqDone.
// - Hold grant asserted with bus float.
// - Address hold floats address next clock.
`timescale 1ns/1ns
`default_nettype none
`include "bsz_consts.vh"

module bsz_bus_unit #(
    parameter AW = 32                            // Physical address width.
) (
    input  wire          clk,
    input  wire          rst,
    input  wire          reqValid,               // Core request, one-cycle pulse.
    input  wire [AW-1:0] reqAddr,                // Core physical address.
    input  wire [3:0]    reqByteEn,              // Byte lanes wanted, active high.
    input  wire [1:0]    reqCycleType,           // Cycle type bits from the core.
    input  wire [1:0]    reqPageAttr,            // Page attribute bits.
    input  wire          reqLock,                // Locked cycle request.
    input  wire          reqPseudoLock,          // Pseudo-locked cycle request.
    input  wire          mgmtMode,               // Core is in management mode.
    input  wire          stopState,              // Stop grant or stop clock.
    input  wire          holdRequest,            // Bus hold request.
    input  wire          addr_yield_request,     // Address hold request.
    input  wire          addr_bit20_mask_n,      // Asynchronous mask input.
    input  wire          width16_sel_n,
    input  wire          width8_sel_n,
    input  wire          burst_done_n,           // Transfer-done indication.
    output reg           reqDone,                // Whole request complete pulse.
    output reg  [AW-1:0] addrOut,
    output reg           addrOe,
    output reg  [3:0]    byte_lane_en_n,
    output reg  [1:0]    page_cache_attr,
    output reg  [1:0]    cycleType,
    output reg           lockN,
    output reg           pseudo_locked_n,
    output reg           addr_strobe_n,
    output reg           final_transfer_n,
    output reg           ctrlOe,                 // Enable of the bus-floated control group outputs.
    output reg           bus_want,
    output reg           bus_yield_grant,
    output reg           mgmt_mode_active_n
);

    // ------------------------------------------------------------
    // Overview
    // ------------------------------------------------------------

    // The unit takes one core request at a time and turns it into one or more
    // bus cycles. Each cycle has an address phase with a one-clock strobe and a
    // data phase that lasts until the slave reports the transfer done.
    // A slave that asserts a narrow width select only moves part of the lanes,
    // so the unit loops back to a fresh address phase for the lanes left over.
    // Every output is registered. This costs one clock of latency on each
    // decision, but it keeps the pins free of glitches from the decode logic.
    // The two output enables split the pins into an address group and a
    // control group, so that address hold and bus hold can float each group
    // on its own without extra per-pin enables.
    // Bus request, hold grant and the management flag are never floated.
    // A limitation: bus hold is only granted while the sequencer is idle, so a
    // hold request that arrives mid-request waits for that request to finish.

    // ------------------------------------------------------------
    // Lane helpers
    // ------------------------------------------------------------

    // Lowest set lane in a mask; used to work out the lanes a narrow cycle moved.
    function [1:0] lowLane;
        input [3:0] m;
        begin
            if (m[0]) lowLane = 2'h0;
            else if (m[1]) lowLane = 2'h1;
            else if (m[2]) lowLane = 2'h2;
            else lowLane = 2'h3;
        end
    endfunction

    // Lanes served by one cycle of the given width starting at a lane.
    function [3:0] servedLanes;
        input [1:0] w;
        input [1:0] lane;
        begin
            if (w == `BSZ_W8) servedLanes = 4'h1 << lane;
            else if (w == `BSZ_W16) servedLanes = lane[1] ? 4'hc : 4'h3;
            else servedLanes = 4'hf;
        end
    endfunction

    // ------------------------------------------------------------
    // Mask synchroniser
    // ------------------------------------------------------------

    reg maskMeta;                                // First stage, read only by maskSync.
    reg maskSync;                                // Stable mask level, active low.

    // Two flops because the mask pin is not tied to our clock.
    // The first stage may go metastable; only the second stage is used by the
    // address logic, which costs two clocks of latency on every mask change.
    // Both stages reset to the unmasked level, so the first request after
    // reset never sees a stray mask.
    always @(posedge clk) begin
        if (rst) begin
            maskMeta <= `BSZ_INACTIVE;
            maskSync <= `BSZ_INACTIVE;
        end else begin
            maskMeta <= addr_bit20_mask_n;
            maskSync <= maskMeta;
        end
    end

    // ------------------------------------------------------------
    // Bus cycle sequencer
    // ------------------------------------------------------------

    reg [1:0]    state;                          // Controller state.
    reg [3:0]    lanesLeft;                      // Lanes still to move.
    reg [AW-1:0] curAddr;                        // Masked request address.
    reg [1:0]    widthSeen;                      // Width sampled last clock.
    wire [AW-1:0] maskedAddr;                    // Address after bit 20 mask.
    wire [1:0]   lane;                           // Lowest outstanding lane.
    wire [3:0]   doneLanes;                      // Lanes this cycle moved.

    // The mask is applied before any lookup or bus cycle sees the address.
    assign maskedAddr = maskSync ? reqAddr
                      : (reqAddr & ~({{(AW-1){1'b0}}, 1'b1} << `BSZ_A20_BIT));
    assign lane = lowLane(lanesLeft);
    assign doneLanes = servedLanes(widthSeen, lane) & lanesLeft;

    // Sequencer: one address phase, then data until done; narrow widths repeat.
    // A stop state freezes the sequencer where it stands, so a request in
    // flight resumes once the stop state ends. Strobes are parked inactive
    // meanwhile so that no slave sees a new cycle start.
    always @(posedge clk) begin
        if (rst) begin
            state            <= `BSZ_ST_IDLE;
            lanesLeft        <= 4'h0;
            curAddr          <= {AW{1'b0}};
            widthSeen        <= `BSZ_W32;
            reqDone          <= 1'b0;
            addrOut          <= {AW{1'b0}};
            addrOe           <= 1'b0;
            byte_lane_en_n   <= 4'hf;
            page_cache_attr  <= 2'h0;
            cycleType        <= 2'h0;
            lockN            <= `BSZ_INACTIVE;
            pseudo_locked_n  <= `BSZ_INACTIVE;
            addr_strobe_n    <= `BSZ_INACTIVE;
            final_transfer_n <= `BSZ_INACTIVE;
            ctrlOe           <= 1'b0;
            bus_want         <= 1'b0;
            bus_yield_grant  <= 1'b0;
            mgmt_mode_active_n <= `BSZ_INACTIVE;
        end else begin
            reqDone  <= 1'b0;
            // The width is registered so that the decision at the done edge
            // uses the selects from one clock before, as the slave expects.
            // An 8-bit select wins over a 16-bit one if a slave drives both.
            // Width sampled every clock; the value one clock before done counts.
            if (!width8_sel_n) widthSeen <= `BSZ_W8;
            else if (!width16_sel_n) widthSeen <= `BSZ_W16;
            else widthSeen <= `BSZ_W32;
            // Grant tracks hold while the sequencer is idle, stop states included.
            bus_yield_grant <= holdRequest && state == `BSZ_ST_IDLE;
            ctrlOe <= !(holdRequest && state == `BSZ_ST_IDLE);
            // Address floats the clock after address hold or during bus hold.
            addrOe <= !addr_yield_request
                   && !(holdRequest && state == `BSZ_ST_IDLE);
            if (stopState) begin
                // Strobes parked inactive; remaining outputs but enables, grant and reqDone keep their level.
                addr_strobe_n   <= `BSZ_INACTIVE;
                lockN           <= `BSZ_INACTIVE;
                pseudo_locked_n <= `BSZ_INACTIVE;
            end else begin
                mgmt_mode_active_n <= !mgmtMode;
                addr_strobe_n <= `BSZ_INACTIVE;
                case (state)
                    `BSZ_ST_IDLE: begin
                        bus_want <= reqValid;
                        if (reqValid && !holdRequest) begin
                            state           <= `BSZ_ST_ADDR;
                            lanesLeft       <= reqByteEn;
                            curAddr         <= maskedAddr;
                            page_cache_attr <= reqPageAttr;
                            cycleType       <= reqCycleType;
                            lockN           <= !reqLock;
                            pseudo_locked_n <= !reqPseudoLock;
                        end
                    end
                    `BSZ_ST_ADDR: begin
                        // A new address phase for each narrow piece.
                        addr_strobe_n    <= 1'b0;
                        byte_lane_en_n   <= ~lanesLeft;
                        addrOut          <= {curAddr[AW-1:2], 2'h0};
                        final_transfer_n <= 1'b0;
                        bus_want         <= 1'b0;
                        state            <= `BSZ_ST_DATA;
                    end
                    `BSZ_ST_DATA: begin
                        if (!burst_done_n) begin
                            if ((lanesLeft & ~doneLanes) == 4'h0) begin
                                state            <= `BSZ_ST_IDLE;
                                reqDone          <= 1'b1;
                                final_transfer_n <= `BSZ_INACTIVE;
                                lockN            <= `BSZ_INACTIVE;
                                pseudo_locked_n  <= `BSZ_INACTIVE;
                            end else begin
                                lanesLeft <= lanesLeft & ~doneLanes;
                                state     <= `BSZ_ST_ADDR;
                            end
                        end
                    end
                    default: state <= `BSZ_ST_IDLE;
                endcase
            end
        end
    end

endmodule
`default_nettype wire

// file: verilog/bsz_consts.vh
`ifndef BSZ_CONSTS_VH
`define BSZ_CONSTS_VH

// Bus width codes decided from the two width-select inputs.
`define BSZ_W32         2'h0
`define BSZ_W16         2'h1
`define BSZ_W8          2'h2

// Bit position of the maskable physical address bit.
`define BSZ_A20_BIT     20

// Idle levels of active-low strobes.
`define BSZ_INACTIVE    1'h1

// Controller states.
`define BSZ_ST_IDLE     2'h0
`define BSZ_ST_ADDR     2'h1
`define BSZ_ST_DATA     2'h2

// Bytes in a full-width transfer.
`define BSZ_FULL_BYTES  3'h4

`endif

// file: tb/bsz_bus_unit_chk.sv
`timescale 1ns/1ns
`default_nettype none
// ----------------------------------------
// Pin checker for the bus unit.
// ----------------------------------------
module bsz_bus_unit_chk #(
    parameter AW = 32
) (
    input wire logic          clk, rst, stopState, holdRequest, addr_yield_request,
    input wire logic          addr_bit20_mask_n, width16_sel_n, width8_sel_n, burst_done_n,
    input wire logic          reqDone, addrOe, lockN, pseudo_locked_n, addr_strobe_n,
    input wire logic          final_transfer_n, ctrlOe, bus_want, bus_yield_grant,
    input wire logic [AW-1:0] addrOut,
    input wire logic [3:0]    byte_lane_en_n
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    // Done edge of a piece whose width was decided as full.
    sequence fullEnd;
        !burst_done_n && $past(width8_sel_n) && $past(width16_sel_n);
    endsequence
    // Done edge of a narrow first piece, all four lanes still open.
    sequence narrowFirst;
        !burst_done_n && !($past(width8_sel_n) && $past(width16_sel_n)) && byte_lane_en_n == 4'h0;
    endsequence
    stop_park_a: assert property (stopState |=> addr_strobe_n && lockN && pseudo_locked_n)
        else $error("strobe or lock active in stop state");
    stop_keep_a: assert property (stopState |=> $stable(byte_lane_en_n) && $stable(bus_want)
        && $stable(final_transfer_n) && $stable(addrOut[3:2])) else $error("stop state moved pin");
    grant_float_a: assert property (bus_yield_grant |-> !ctrlOe && !addrOe)
        else $error("grant without float");
    grant_cause_a: assert property ($rose(bus_yield_grant) |-> $past(holdRequest))
        else $error("grant without hold request");
    grant_drop_a: assert property (bus_yield_grant && !holdRequest |=> !bus_yield_grant)
        else $error("grant kept after hold");
    addr_yield_request_float_a: assert property (addr_yield_request |=> !addrOe)
        else $error("address driven in address hold");
    ctrl_kept_a: assert property (addr_yield_request && !holdRequest && !bus_yield_grant
        |=> ctrlOe) else $error("control floated in address hold");
    mask_bit20_a: assert property (!addr_bit20_mask_n[*6] ##0 !addr_strobe_n |-> !addrOut[20])
        else $error("bit 20 not masked");
    full_done_a: assert property (fullEnd |=> reqDone) else $error("full piece not done");
    narrow_split_a: assert property (narrowFirst |=> !reqDone)
        else $error("narrow request ended early");
endmodule
bind bsz_bus_unit bsz_bus_unit_chk #(.AW(AW)) bsz_bus_unit_chk_inst (.clk, .rst, .stopState,
    .holdRequest, .addr_yield_request, .addr_bit20_mask_n, .width16_sel_n, .width8_sel_n,
    .burst_done_n, .reqDone, .addrOe, .lockN, .pseudo_locked_n, .addr_strobe_n,
    .final_transfer_n, .ctrlOe, .bus_want, .bus_yield_grant, .addrOut, .byte_lane_en_n);
`default_nettype wire

// file: tb/bsz_slave_model.sv
`timescale 1ns/1ns
`default_nettype none
`include "bsz_consts.vh"
// ----------------------------------------
// Slave: answers each strobe, maybe slowly.
// ----------------------------------------
module bsz_slave_model (
    input  wire logic       clk,
    input  wire logic       addr_strobe_n,
    input  wire logic [1:0] widthMode,
    input  wire logic [1:0] slowCyc,
    output var  logic       width16_sel_n,
    output var  logic       width8_sel_n,
    output var  logic       burst_done_n
);
    // Pull-ups hold every line high while idle.
    initial begin
        {width16_sel_n, width8_sel_n, burst_done_n} = 3'h7;
        forever begin
            @(posedge clk);
            if (addr_strobe_n === 1'b0) begin
                repeat (slowCyc) @(posedge clk);
                width16_sel_n <= (widthMode != `BSZ_W16);
                width8_sel_n <= (widthMode != `BSZ_W8);
                @(posedge clk);
                burst_done_n <= 1'b0;
                @(posedge clk);
                {width16_sel_n, width8_sel_n, burst_done_n} <= 3'h7;
            end
        end
    end
endmodule
`default_nettype wire

// file: tb/bsz_bus_unit_test.sv
`timescale 1ns/1ns
`default_nettype none
module bsz_bus_unit_test;
    logic clk = 1'b0, rst = 1'b1, reqValid = 1'b0, stopState = 1'b0, holdRequest = 1'b0;
    logic addr_yield_request = 1'b0, addr_bit20_mask_n = 1'b1;
    logic [31:0] reqAddr = 32'h0, seen;
    logic [3:0]  reqByteEn = 4'hf;
    logic [1:0]  widthMode = 2'h0, slowCyc = 2'h0;
    wire         width16_sel_n, width8_sel_n, burst_done_n, reqDone, addrOe, addr_strobe_n;
    wire         ctrlOe, bus_yield_grant, mgmtActN;
    wire  [1:0]  pageAttr, cycType;
    wire  [31:0] addrOut;
    int          error_cnt = 0, comparisons = 0, n;
    bsz_bus_unit bsz_bus_unit_inst (.clk, .rst, .reqValid, .reqAddr, .reqByteEn,
        .reqCycleType(2'h1), .reqPageAttr(2'h2), .reqLock(1'b0), .reqPseudoLock(1'b0),
        .mgmtMode(1'b0), .stopState, .holdRequest, .addr_yield_request, .addr_bit20_mask_n,
        .width16_sel_n, .width8_sel_n, .burst_done_n, .reqDone, .addrOut, .addrOe,
        .byte_lane_en_n(), .page_cache_attr(pageAttr), .cycleType(cycType), .lockN(),
        .pseudo_locked_n(), .addr_strobe_n, .final_transfer_n(), .ctrlOe, .bus_want(),
        .bus_yield_grant, .mgmt_mode_active_n(mgmtActN));
    bsz_slave_model bsz_slave_model_inst (.clk, .addr_strobe_n, .widthMode, .slowCyc,
        .width16_sel_n, .width8_sel_n, .burst_done_n);
    initial forever #5 clk = ~clk;
    // Compare one value and count it.
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            error_cnt++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask
    // One request; counts strobes until done, bounded so a hang cannot stall.
    task automatic run_req(input logic [31:0] a, input logic [3:0] be, input logic [1:0] m);
        widthMode <= m;
        reqAddr <= a;
        reqByteEn <= be;
        reqValid <= 1'b1;
        @(posedge clk);
        reqValid <= 1'b0;
        n = 0;
        for (int i = 0; i < 80 && reqDone !== 1'b1; i++) begin
            @(posedge clk);
            if (addr_strobe_n === 1'b0) begin
                n++;
                if (n == 1) seen = addrOut;
            end
        end
        chk("done", 32'h1, {31'h0, reqDone});
    endtask
    task automatic test_width();
        for (int m = 0; m < 3; m++) begin
            slowCyc <= m[1:0];
            run_req(32'h0010_0008, 4'hf, m[1:0]);
            chk("pieces", 32'h1 << m, n);
            chk("address", 32'h0010_0008, seen);
        end
        run_req(32'h0000_0010, 4'h6, 2'h2);
        chk("pieces", 32'h2, n);
        $display("test width finished");
    endtask
    task automatic test_mask();
        addr_bit20_mask_n <= 1'b0;
        repeat (4) @(posedge clk);
        run_req(32'h0013_0004, 4'hf, 2'h0);
        chk("address", 32'h0003_0004, seen);
        addr_bit20_mask_n <= 1'b1;
        $display("test mask finished");
    endtask
    task automatic test_holds();
        holdRequest <= 1'b1;
        repeat (3) @(posedge clk);
        chk("hold pins", 32'h4, {bus_yield_grant, ctrlOe, addrOe});
        holdRequest <= 1'b0;
        addr_yield_request <= 1'b1;
        repeat (2) @(posedge clk);
        chk("addr_yield_request pins", 32'h2, {bus_yield_grant, ctrlOe, addrOe});
        addr_yield_request <= 1'b0;
        stopState <= 1'b1;
        reqValid <= 1'b1;
        holdRequest <= 1'b1;
        @(posedge clk);
        reqValid <= 1'b0;
        repeat (3) @(posedge clk);
        chk("stop grant", 32'h3, {bus_yield_grant, addr_strobe_n});
        chk("stop keep", 32'h13, {pageAttr, cycType, mgmtActN});
        holdRequest <= 1'b0;
        stopState <= 1'b0;
        repeat (8) @(posedge clk);
        chk("refused", 32'h1, {31'h0, addr_strobe_n});
        $display("test holds finished");
    endtask
    task automatic report_and_stop();
        $display("comparisons %0d, mismatches %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    initial begin
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        repeat (3) @(posedge clk);
        test_width();
        test_mask();
        test_holds();
        report_and_stop();
    end
    initial begin
        repeat (3000) @(posedge clk);
        error_cnt++;
        report_and_stop();
    end
endmodule
`default_nettype wire
